// ===== core/vccr_pkg.sv
// package: offsets, fields and reset values of the channel capability bank
package vccr_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // byte offsets of the documented words
  localparam logic [11:0] OFF_HEADER   = 12'h200;
  localparam logic [11:0] OFF_CAP_ONE  = 12'h204;
  localparam logic [11:0] OFF_CAP_TWO  = 12'h208;
  localparam logic [11:0] OFF_CONTROL  = 12'h20C;
  // local control and status words
  localparam logic [11:0] OFF_LOCK_CTL = 12'h3F0;
  localparam logic [11:0] OFF_BANK_STS = 12'h3F4;

  // header fields
  localparam int unsigned ID_LSB   = 0;
  localparam int unsigned ID_W     = 16;
  localparam int unsigned VER_LSB  = 16;
  localparam int unsigned VER_W    = 4;
  localparam int unsigned NEXT_LSB = 20;
  localparam int unsigned NEXT_W   = 12;
  localparam logic [15:0] ID_VAL    = 16'h0002;
  localparam logic [3:0]  VER_VAL   = 4'h1;
  localparam logic [11:0] NEXT_RST  = 12'h000;

  // first capability word fields
  localparam int unsigned ADD_CNT_LSB = 0;
  localparam int unsigned LP_CNT_LSB  = 4;
  localparam int unsigned TBASE_LSB   = 8;
  localparam int unsigned ESIZE_LSB   = 10;
  localparam logic [2:0]  ADD_CNT_VAL = 3'h0;
  localparam logic [2:0]  LP_CNT_VAL  = 3'h0;
  localparam logic [1:0]  TBASE_VAL   = 2'h0;

  // second capability word fields
  localparam int unsigned ARB_CAP_LSB = 0;
  localparam int unsigned TBL_LOC_LSB = 24;
  localparam logic [7:0]  ARB_CAP_VAL = 8'h00;
  localparam logic [7:0]  TBL_LOC_VAL = 8'h00;

  // control word fields
  localparam int unsigned LOAD_LSB    = 0;
  localparam int unsigned SEL_LSB     = 1;
  localparam logic        LOAD_VAL    = 1'b0;
  localparam logic [2:0]  SEL_VAL     = 3'h0;

  // local words
  localparam int unsigned LOCK_BIT     = 0;
  localparam logic        LOCK_RST     = 1'b0;
  localparam int unsigned STS_IGN_BIT  = 0;
  localparam int unsigned STS_UNM_BIT  = 1;
  localparam int unsigned STS_UP_BIT   = 2;
  localparam int unsigned STS_RDY_BIT  = 3;

  // arbitration table entry size encoding
  typedef enum logic [1:0] {
    ESIZE_ONE   = 2'h0,
    ESIZE_TWO   = 2'h1,
    ESIZE_FOUR  = 2'h2,
    ESIZE_EIGHT = 2'h3
  } vccr_entry_size_e;

  localparam vccr_entry_size_e ESIZE_UP   = ESIZE_FOUR;
  localparam vccr_entry_size_e ESIZE_DOWN = ESIZE_ONE;

endpackage

// ===== core/vccr_lock_field.sv
// lockable writable field: takes write data only while the lock is open
`timescale 1ns/100ps
module vccr_lock_field #(
  parameter int unsigned      WIDTH = 12,
  parameter logic [WIDTH-1:0] RST   = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic             locked,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] field_q;
  logic [WIDTH-1:0] field_d;
  logic             take;

  // a locked write leaves the field untouched
  assign take    = wr_en && !locked;
  assign field_d = take ? wdata : field_q;
  assign value   = field_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      field_q <= RST;
    end else begin
      field_q <= field_d;
    end
  end

endmodule

// ===== core/vccr_bank.sv
// channel capability register bank: header, two capability words, control word
//
// Overview of operation
// - header identifier field reads constant 0x2, naming a channel capability.
// - header version field reads constant 0x1.
// - header link-to-next defaults to zero; writable only while unlocked.
// - additional channel count reads zero: only the default channel exists.
// - low-priority additional channel count reads zero.
// - weighted timing base reads zero; weighted round robin absent.
// - entry size reads 0x2 on the upstream port, 0x0 downstream.
// - entry size codes: 0 one bit, 1 two, 2 four, 3 eight bits.
// - channel arbitration capability reads zero; bits 4 to 7 reserved.
// - channel arbitration capability meaningful only with low-priority count above zero.
// - channel arbitration table location reads zero: no table present.
// - load-table control bit always reads zero and does nothing.
// - channel arbitration selector reads zero and does nothing.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module vccr_bank (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        upstream_strap,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [11:0] link_to_next,
  output logic      [1:0]  port_arb_entry_size,
  output logic             port_is_upstream,
  output logic             write_locked
);

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic hit_header;
  logic hit_cap_one;
  logic hit_cap_two;
  logic hit_control;
  logic hit_lock;
  logic hit_status;
  logic hit_any;

  assign hit_header  = (reg_addr == vccr_pkg::OFF_HEADER);
  assign hit_cap_one = (reg_addr == vccr_pkg::OFF_CAP_ONE);
  assign hit_cap_two = (reg_addr == vccr_pkg::OFF_CAP_TWO);
  assign hit_control = (reg_addr == vccr_pkg::OFF_CONTROL);
  assign hit_lock    = (reg_addr == vccr_pkg::OFF_LOCK_CTL);
  assign hit_status  = (reg_addr == vccr_pkg::OFF_BANK_STS);
  assign hit_any     = hit_header | hit_cap_one | hit_cap_two
                     | hit_control | hit_lock | hit_status;

  logic wr_header;
  logic wr_ro_word;
  logic wr_lock;
  logic wr_status;
  logic wr_unmapped;
  logic rd_unmapped;

  assign wr_header   = reg_wr && hit_header;
  // these three words hold no writable bit at all
  assign wr_ro_word  = reg_wr && (hit_cap_one | hit_cap_two | hit_control);
  assign wr_lock     = reg_wr && hit_lock;
  assign wr_status   = reg_wr && hit_status;
  assign wr_unmapped = reg_wr && !hit_any;
  assign rd_unmapped = reg_rd && !hit_any;

  // ------------------------------------------------------------------
  // port role strap, caught on the first edge after reset release
  // ------------------------------------------------------------------
  logic strap_done_q;
  logic strap_done_d;
  logic upstream_q;
  logic upstream_d;

  assign strap_done_d = 1'b1;
  // sampling once keeps the reported geometry stable if the pin wanders
  assign upstream_d   = strap_done_q ? upstream_q : upstream_strap;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      upstream_q   <= 1'b0;
    end else begin
      strap_done_q <= strap_done_d;
      upstream_q   <= upstream_d;
    end
  end

  // ------------------------------------------------------------------
  // write lock
  // ------------------------------------------------------------------
  logic lock_q;
  logic lock_d;

  assign lock_d = wr_lock ? reg_wdata[vccr_pkg::LOCK_BIT] : lock_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q <= vccr_pkg::LOCK_RST;
    end else begin
      lock_q <= lock_d;
    end
  end

  // ------------------------------------------------------------------
  // header: identifier and version fixed, link-to-next lockable
  // ------------------------------------------------------------------
  logic [11:0] next_value;
  logic [11:0] next_wdata;

  assign next_wdata = reg_wdata[vccr_pkg::NEXT_LSB +: vccr_pkg::NEXT_W];

  vccr_lock_field #(
    .WIDTH (vccr_pkg::NEXT_W),
    .RST   (vccr_pkg::NEXT_RST)
  ) u_next_field (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .wr_en   (wr_header),
    .locked  (lock_q),
    .wdata   (next_wdata),
    .value   (next_value)
  );

  logic [31:0] word_header;

  // identifier and version bits of a header write are dropped
  always_comb begin
    word_header                                         = 32'h00000000;
    word_header[vccr_pkg::ID_LSB +: vccr_pkg::ID_W]     = vccr_pkg::ID_VAL;
    word_header[vccr_pkg::VER_LSB +: vccr_pkg::VER_W]   = vccr_pkg::VER_VAL;
    word_header[vccr_pkg::NEXT_LSB +: vccr_pkg::NEXT_W] = next_value;
  end

  // ------------------------------------------------------------------
  // first capability word
  // ------------------------------------------------------------------
  logic [2:0]  add_cnt;
  logic [2:0]  lp_cnt;
  logic [1:0]  timing_base;
  logic [1:0]  entry_size;
  logic [31:0] word_cap_one;

  assign add_cnt     = vccr_pkg::ADD_CNT_VAL;
  assign lp_cnt      = vccr_pkg::LP_CNT_VAL;
  assign timing_base = vccr_pkg::TBASE_VAL;
  // before the strap is caught the port reads as downstream
  assign entry_size  = upstream_q ? vccr_pkg::ESIZE_UP : vccr_pkg::ESIZE_DOWN;

  // reserved gaps at bits 3 and 7 and above bit 11 stay zero
  always_comb begin
    word_cap_one                             = 32'h00000000;
    word_cap_one[vccr_pkg::ADD_CNT_LSB +: 3] = add_cnt;
    word_cap_one[vccr_pkg::LP_CNT_LSB +: 3]  = lp_cnt;
    word_cap_one[vccr_pkg::TBASE_LSB +: 2]   = timing_base;
    word_cap_one[vccr_pkg::ESIZE_LSB +: 2]   = entry_size;
  end

  // ------------------------------------------------------------------
  // second capability word
  // ------------------------------------------------------------------
  logic        lp_present;
  logic [7:0]  arb_cap;
  logic [7:0]  tbl_loc;
  logic [31:0] word_cap_two;

  assign lp_present = (lp_cnt != 3'h0);
  // without a low-priority group the field carries no meaning and reads zero
  assign arb_cap    = lp_present ? vccr_pkg::ARB_CAP_VAL : 8'h00;
  assign tbl_loc    = vccr_pkg::TBL_LOC_VAL;

  always_comb begin
    word_cap_two                             = 32'h00000000;
    word_cap_two[vccr_pkg::ARB_CAP_LSB +: 8] = arb_cap;
    word_cap_two[vccr_pkg::TBL_LOC_LSB +: 8] = tbl_loc;
  end

  // ------------------------------------------------------------------
  // control word: both fields inert
  // ------------------------------------------------------------------
  logic        load_bit;
  logic [2:0]  arb_sel;
  logic [31:0] word_control;

  assign load_bit = vccr_pkg::LOAD_VAL;
  assign arb_sel  = vccr_pkg::SEL_VAL;

  always_comb begin
    word_control                         = 32'h00000000;
    word_control[vccr_pkg::LOAD_LSB]     = load_bit;
    word_control[vccr_pkg::SEL_LSB +: 3] = arb_sel;
  end

  // ------------------------------------------------------------------
  // bank status: sticky flags, write one to clear, set wins
  // ------------------------------------------------------------------
  // index 0 ignored write, index 1 unmapped access
  logic [1:0] sticky_set;
  logic [1:0] sticky_clr;
  logic [1:0] sticky_q;

  // a write that lands on fixed bits only, or on a locked field
  assign sticky_set[0] = wr_ro_word || (wr_header && lock_q);
  assign sticky_set[1] = wr_unmapped || rd_unmapped;
  assign sticky_clr[0] = wr_status && reg_wdata[vccr_pkg::STS_IGN_BIT];
  assign sticky_clr[1] = wr_status && reg_wdata[vccr_pkg::STS_UNM_BIT];

  // set beats a clear in the same cycle so no event is lost
  for (genvar i = 0; i < 2; i++) begin : g_sticky
    logic flag_q;
    logic flag_d;

    assign flag_d      = sticky_set[i] | (flag_q & ~sticky_clr[i]);
    assign sticky_q[i] = flag_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        flag_q <= 1'b0;
      end else begin
        flag_q <= flag_d;
      end
    end
  end

  logic [31:0] word_lock;
  logic [31:0] word_status;

  always_comb begin
    word_lock                     = 32'h00000000;
    word_lock[vccr_pkg::LOCK_BIT] = lock_q;
  end

  always_comb begin
    word_status                        = 32'h00000000;
    word_status[vccr_pkg::STS_IGN_BIT] = sticky_q[0];
    word_status[vccr_pkg::STS_UNM_BIT] = sticky_q[1];
    word_status[vccr_pkg::STS_UP_BIT]  = upstream_q;
    word_status[vccr_pkg::STS_RDY_BIT] = strap_done_q;
  end

  // ------------------------------------------------------------------
  // read path: data stands only in the cycle after the strobe
  // ------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // an unmapped address answers zero
  assign rd_mux = hit_header  ? word_header  :
                  hit_cap_one ? word_cap_one :
                  hit_cap_two ? word_cap_two :
                  hit_control ? word_control :
                  hit_lock    ? word_lock    :
                  hit_status  ? word_status  : 32'h00000000;

  assign rdata_d = reg_rd ? rd_mux : 32'h00000000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs toward the port logic, all from flip-flops except port_arb_entry_size, decoded from upstream_q
  // ------------------------------------------------------------------
  assign reg_rdata           = rdata_q;
  assign link_to_next        = next_value;
  assign port_arb_entry_size = entry_size;
  assign port_is_upstream    = upstream_q;
  assign write_locked        = lock_q;

endmodule

// ===== tb/vccr_bank_chk.sv
// assertion checker for the channel capability register bank
`timescale 1ns/100ps
module vccr_bank_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        upstream_strap,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [11:0] link_to_next,
  input wire logic [1:0]  port_arb_entry_size,
  input wire logic        port_is_upstream,
  input wire logic        write_locked
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  wire        wr_hdr  = reg_wr && reg_addr == 12'h200;
  wire [11:0] wr_next = reg_wdata[31:20];

  a_hdr_read: assert property (reg_rd && reg_addr == 12'h200 |=>
    reg_rdata == {$past(link_to_next), 4'h1, 16'h0002}) else $error("header read wrong");
  a_cap_one_read: assert property (reg_rd && reg_addr == 12'h204 |=>
    reg_rdata == {20'h0, $past(port_arb_entry_size), 10'h0}) else $error("cap one read wrong");
  a_size_code: assert property (port_arb_entry_size == (port_is_upstream ? 2'h2 : 2'h0))
    else $error("entry size code wrong");
  a_cap_two_zero: assert property (reg_rd && reg_addr == 12'h208 |=> reg_rdata == 32'h0)
    else $error("cap two not zero");
  a_control_zero: assert property (reg_rd && reg_addr == 12'h20C |=> reg_rdata == 32'h0)
    else $error("control not zero");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_locked_hold: assert property (wr_hdr && write_locked |=> $stable(link_to_next))
    else $error("locked link changed");
  a_next_take: assert property (wr_hdr && !write_locked |=> link_to_next == $past(wr_next))
    else $error("unlocked link write lost");
endmodule

bind vccr_bank vccr_bank_chk i_chk (.sys_clk(sys_clk), .rst_n(rst_n), .upstream_strap(upstream_strap),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .link_to_next(link_to_next), .port_arb_entry_size(port_arb_entry_size),
  .port_is_upstream(port_is_upstream), .write_locked(write_locked));

// ===== tb/tb.sv
// self-checking bench for the channel capability register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        upstream_strap = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] link_to_next;
  logic [1:0]  port_arb_entry_size;
  logic        port_is_upstream;
  logic        write_locked;
  int          failures = 0;
  int          checks_done = 0;
  int          nxt_m, up_m, ign_m, unm_m;
  logic [31:0] d;

  always #50 sys_clk = ~sys_clk;

  vccr_bank i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .upstream_strap(upstream_strap), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_to_next(link_to_next), .port_arb_entry_size(port_arb_entry_size),
    .port_is_upstream(port_is_upstream), .write_locked(write_locked));

  function automatic logic [31:0] hdr();
    return {nxt_m[11:0], 4'h1, 16'h0002};
  endfunction
  function automatic logic [31:0] cap1();
    return {20'h0, (up_m != 0) ? 2'h2 : 2'h0, 10'h0};
  endfunction
  function automatic logic [31:0] sts();
    return {28'h0, 1'b1, up_m[0], unm_m[0], ign_m[0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // data stand one cycle only, so compare mid-cycle after the strobe edge
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK(n, e, reg_rdata)
  endtask

  initial begin
    repeat (4000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  initial begin
    void'($urandom(32'h42B9));
    for (int s = 0; s < 2; s++) begin
      // second pass resets mid-run with state already changed
      if (s != 0) begin
        @(posedge sys_clk);
      end
      rst_n <= 1'b0;
      upstream_strap <= s[0];
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      nxt_m = 0;
      up_m = s;
      ign_m = 0;
      unm_m = 0;
      rd(12'h200, hdr(), "header");
      rd(12'h204, cap1(), "cap_one");
      rd(12'h208, 32'h0, "cap_two");
      rd(12'h20C, 32'h0, "control");
      rd(12'h3F4, sts(), "status");
      `CHK("entry_size", (s != 0) ? 2'h2 : 2'h0, port_arb_entry_size)
      `CHK("port_is_upstream", s[0], port_is_upstream)
      // role is caught once; a later strap change must not show
      @(posedge sys_clk);
      upstream_strap <= ~s[0];
      $display("reset values strap %0d done", s);
      for (int i = 0; i < 4; i++) begin
        d = {$urandom} & 32'hFFF00000 | 32'h00010002;
        wr(12'h200, d);
        nxt_m = d[31:20];
        rd(12'h200, hdr(), "header");
        `CHK("link_to_next", nxt_m[11:0], link_to_next)
      end
      d = $urandom | 32'h000FFFFF;
      wr(12'h200, {nxt_m[11:0], d[19:0]});
      rd(12'h200, hdr(), "header");
      for (int k = 0; k < 3; k++) begin
        wr(12'h204 + 12'(4 * k), $urandom | 32'hFFFF0F0F);
        rd(12'h204 + 12'(4 * k), (k == 0) ? cap1() : 32'h0, "ro_word");
      end
      ign_m = 1;
      $display("header and read-only writes done");
      wr(12'h3F0, 32'h1);
      @(negedge sys_clk);
      `CHK("write_locked", 1'b1, write_locked)
      wr(12'h200, $urandom);
      rd(12'h200, hdr(), "locked_header");
      rd(12'h3F0, 32'h1, "lock_word");
      wr(12'h3F0, 32'h0);
      wr(12'h210, $urandom);
      unm_m = 1;
      rd(12'h210, 32'h0, "unmapped");
      rd(12'h3F4, sts(), "status");
      wr(12'h3F4, 32'h3);
      ign_m = 0;
      unm_m = 0;
      rd(12'h3F4, sts(), "status");
      $display("lock and status pass %0d done", s);
    end
    close_out();
  end
endmodule
